// ==== hw/pullup_cfg.svh ====
/*
  Register offsets, implemented-bit masks and reset values for the pull-up option block.
  Assumes inclusion by the design file only.
*/
`ifndef PULLUP_CFG_SVH
`define PULLUP_CFG_SVH
`define PU_NUM_REGS 13
`define PU_RESET_VAL 8'h00
`define PU_ADDR_W 16
`define PU_OFF_PORT1 16'hff31
`define PU_OFF_PORT3 16'hff33
`define PU_OFF_PORT4 16'hff34
`define PU_OFF_PORT8 16'hff38
`define PU_OFF_PORT9 16'hff39
`define PU_OFF_PORT10 16'hff3a
`define PU_OFF_PORT11 16'hff3b
`define PU_OFF_PORT12 16'hff3c
`define PU_OFF_PORT13 16'hff3d
`define PU_OFF_PORT14 16'hff3e
`define PU_OFF_PORT15 16'hff3f
`define PU_OFF_EXT0 8'h8d
`define PU_OFF_EXT1 8'h90
`define PU_MASK_PORT1 8'h0e
`define PU_MASK_PORT3 8'h0f
`define PU_MASK_PORT4 8'h3f
`define PU_MASK_LOW4 8'h0f
`define PU_MASK_PORT12 8'h01
`define PU_MASK_EXT 8'h3f
`endif

// ==== hw/pullup_pkg.sv ====
/*
  Types shared by the pull-up option block.
  Assumes the constants header sits beside it.
*/
`default_nettype none
package pullup_pkg;
  typedef logic [7:0] pu_byte_t;
  typedef struct packed {
    logic we;
    logic bit_op;
    logic [2:0] bit_pos;
    logic bit_val;
    logic [15:0] addr;
    pu_byte_t wdata;
  } mem_req_t;
  typedef struct packed {
    logic we;
    logic [7:0] addr;
    pu_byte_t wdata;
  } ext_req_t;
endpackage
`default_nettype wire

// ==== hw/port_pullup_option_control.sv ====
/*
  Pull-up option registers for the normal ports (memory bus, bit or byte writes)
  and two extended banks (extended register path), with per-pin pull-up enables.
  Assumes port mode and alternate-output qualifiers arrive synchronous to sys_clk_i.
*/
`default_nettype none
`include "pullup_cfg.svh"

// Functional notes
// RL1: Pull-up on only when selected and input
// RL2: Output or alternate output forces pull-up off
// RL3: Reset clears every selection register
// RL4: Normal banks take bit and byte writes
// RL5: Extended banks reachable only via extended path
// RL6: Bit one connects, zero disconnects
// RL7: Extended banks use bits zero to five
// RL8: Software sets port-4 pins two-five after reset
// RL9: Unimplemented bits read zero; enable lags one
module port_pullup_option_control
  import pullup_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire mem_req_t mem_req_i,
  input wire ext_req_t ext_req_i,
  input wire logic [`PU_NUM_REGS*8-1:0] pin_input_mode_i,
  input wire logic [`PU_NUM_REGS*8-1:0] pin_alt_out_i,
  output logic [7:0] mem_rdata_o,
  output logic mem_hit_o,
  output logic [7:0] ext_rdata_o,
  output logic ext_hit_o,
  output logic [`PU_NUM_REGS*8-1:0] pullup_en_o
);
  localparam int NREG = `PU_NUM_REGS;
  localparam int NMEM = NREG - 2;

  pu_byte_t sel_reg [NREG];
  pu_byte_t sel_next [NREG];
  logic [NREG-1:0] hit;
  pu_byte_t mask [NREG];
  logic [15:0] off [NMEM];

  // Normal bank offsets in register index order
  assign off = '{
    `PU_OFF_PORT1,
    `PU_OFF_PORT3,
    `PU_OFF_PORT4,
    `PU_OFF_PORT8,
    `PU_OFF_PORT9,
    `PU_OFF_PORT10,
    `PU_OFF_PORT11,
    `PU_OFF_PORT12,
    `PU_OFF_PORT13,
    `PU_OFF_PORT14,
    `PU_OFF_PORT15
  };
  // Implemented-bit masks in register index order
  assign mask = '{
    `PU_MASK_PORT1,
    `PU_MASK_PORT3,
    `PU_MASK_PORT4,
    `PU_MASK_LOW4,
    `PU_MASK_LOW4,
    `PU_MASK_LOW4,
    `PU_MASK_LOW4,
    `PU_MASK_PORT12,
    `PU_MASK_LOW4,
    `PU_MASK_LOW4,
    `PU_MASK_LOW4,
    `PU_MASK_EXT, // see RL7
    `PU_MASK_EXT // see RL7
  };

  // Address decode: normal banks on memory path, extended banks only on extended path
  genvar g;
  generate
    for (g = 0; g < NMEM; g++) begin : g_mem
      assign hit[g] = (mem_req_i.addr == off[g]); // see RL4
    end
  endgenerate
  assign hit[NMEM] = (ext_req_i.addr == `PU_OFF_EXT0); // see RL5
  assign hit[NMEM+1] = (ext_req_i.addr == `PU_OFF_EXT1); // see RL5

  // Next value: byte write or single-bit write, masked to implemented bits
  always_comb begin
    for (int i = 0; i < NREG; i++) begin
      sel_next[i] = sel_reg[i];
      if (i < NMEM) begin
        if (mem_req_i.we && hit[i]) begin
          if (mem_req_i.bit_op) begin
            sel_next[i][mem_req_i.bit_pos] = mem_req_i.bit_val; // see RL4
          end else begin
            sel_next[i] = mem_req_i.wdata; // see RL4
          end
        end
      end else if (ext_req_i.we && hit[i]) begin
        sel_next[i] = ext_req_i.wdata; // see RL5
      end
      sel_next[i] = sel_next[i] & mask[i]; // see RL9
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < NREG; i++) sel_reg[i] <= `PU_RESET_VAL; // see RL3
    end else begin
      for (int i = 0; i < NREG; i++) sel_reg[i] <= sel_next[i];
    end
  end

  // Read mux
  pu_byte_t mem_rd_next;
  logic mem_hit_next;
  always_comb begin
    mem_rd_next = `PU_RESET_VAL;
    for (int i = 0; i < NMEM; i++) begin
      if (hit[i]) mem_rd_next = sel_reg[i]; // see RL9
    end
  end
  assign mem_hit_next = |hit[NMEM-1:0];

  // Extended read select
  pu_byte_t ext_rd_next;
  logic ext_hit_next;
  assign ext_rd_next = hit[NMEM] ? sel_reg[NMEM] : (hit[NMEM+1] ? sel_reg[NMEM+1] : `PU_RESET_VAL); // see RL5
  assign ext_hit_next = hit[NMEM] | hit[NMEM+1]; // see RL5

  // Effective enable: one selects, input mode required, alternate output blocks
  logic [NREG*8-1:0] sel_flat;
  logic [NREG*8-1:0] en_next;
  generate
    for (g = 0; g < NREG; g++) begin : g_flat
      assign sel_flat[g*8 +: 8] = sel_reg[g];
    end
  endgenerate
  assign en_next = sel_flat & pin_input_mode_i & ~pin_alt_out_i; // see RL1 see RL2 see RL6

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mem_rdata_o <= `PU_RESET_VAL;
      mem_hit_o <= 1'b0;
      ext_rdata_o <= `PU_RESET_VAL;
      ext_hit_o <= 1'b0;
      pullup_en_o <= '0; // see RL3
    end else begin
      mem_rdata_o <= mem_rd_next;
      mem_hit_o <= mem_hit_next;
      ext_rdata_o <= ext_rd_next;
      ext_hit_o <= ext_hit_next;
      pullup_en_o <= en_next; // see RL9
    end
  end

  // Write and write-then-read sequences on the extended path and the port 4 bank
  sequence s_ext0_write;
    ext_req_i.we && hit[NMEM];
  endsequence
  sequence s_ext1_write;
    ext_req_i.we && hit[NMEM+1];
  endsequence
  sequence s_ext0_write_read;
    s_ext0_write ##1 hit[NMEM];
  endsequence
  sequence s_ext1_write_read;
    s_ext1_write ##1 hit[NMEM+1];
  endsequence
  sequence s_port4_bit3_write;
    mem_req_i.we && mem_req_i.bit_op && hit[2] && mem_req_i.bit_pos == 3'h3;
  endsequence

  // Enable path checks
  AST_EN_FOLLOWS: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // see RL1
    1'b1 |=> pullup_en_o == $past(en_next)) else $error("Enable not one cycle behind");
  AST_OUT_BLOCKS: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // see RL2
    1'b1 |=> ((pullup_en_o & ~$past(pin_input_mode_i)) == '0)) else $error("Pull-up on output pin");
  AST_ALT_BLOCKS: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // see RL2
    1'b1 |=> ((pullup_en_o & $past(pin_alt_out_i)) == '0)) else $error("Pull-up on alt output");
  AST_SEL_GATES: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // see RL6
    1'b1 |=> ((pullup_en_o & ~$past(sel_flat)) == '0)) else $error("Pull-up on unselected pin");
  AST_RESET_CLEAR: assert property (@(posedge sys_clk_i) // see RL3
    $rose(resetn_i) |-> sel_flat == '0 && pullup_en_o == '0 && !mem_hit_o && !ext_hit_o)
    else $error("Reset left state set");

  // Register write checks
  AST_EXT_TOP_ZERO: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // see RL7
    sel_reg[NMEM][7:6] == 2'b00 && sel_reg[NMEM+1][7:6] == 2'b00) else $error("Extended top bits set");
  AST_BYTE_WRITE: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // see RL4
    mem_req_i.we && !mem_req_i.bit_op && hit[2] |=> sel_reg[2] == ($past(mem_req_i.wdata) & `PU_MASK_PORT4))
    else $error("Byte write lost");
  AST_BIT_WRITE: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // see RL4
    mem_req_i.we && mem_req_i.bit_op && hit[0] && mem_req_i.bit_pos == 3'h1
    |=> sel_reg[0][1] == $past(mem_req_i.bit_val)) else $error("Bit write lost");
  AST_PORT4_BIT_ONLY: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // see RL4
    s_port4_bit3_write |=> ((sel_reg[2] ^ $past(sel_reg[2])) & 8'hf7) == 8'h00)
    else $error("Bit write touched other bits");
  AST_EXT_ONLY: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // see RL5
    !(ext_req_i.we && hit[NMEM]) |=> $stable(sel_reg[NMEM])) else $error("Extended bank changed");
  AST_EXT0_WRITE: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // see RL5
    s_ext0_write |=> sel_reg[NMEM] == ($past(ext_req_i.wdata) & `PU_MASK_EXT))
    else $error("Extended bank 0 write lost");
  AST_EXT1_WRITE: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // see RL5
    s_ext1_write |=> sel_reg[NMEM+1] == ($past(ext_req_i.wdata) & `PU_MASK_EXT))
    else $error("Extended bank 1 write lost");
  AST_UNIMPL_ZERO: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // see RL9
    (sel_reg[7] & ~`PU_MASK_PORT12) == 8'h00) else $error("Unimplemented bit set");
  AST_PORT1_UNIMPL: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // see RL9
    (sel_reg[0] & ~`PU_MASK_PORT1) == 8'h00) else $error("Port 1 unimplemented bit set");

  // Read path checks
  AST_READBACK: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // see RL6
    hit[3] && !mem_req_i.we |=> mem_rdata_o == sel_reg[3] && mem_hit_o) else $error("Readback wrong");
  AST_EXT0_WRITE_READ: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // see RL5
    s_ext0_write_read |=> ext_hit_o && ext_rdata_o == ($past(ext_req_i.wdata, 2) & `PU_MASK_EXT))
    else $error("Extended bank 0 readback wrong");
  AST_EXT1_WRITE_READ: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // see RL5
    s_ext1_write_read |=> ext_hit_o && ext_rdata_o == ($past(ext_req_i.wdata, 2) & `PU_MASK_EXT))
    else $error("Extended bank 1 readback wrong");
  AST_MEM_HIT: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // see RL4
    |hit[NMEM-1:0] |=> mem_hit_o) else $error("Mapped address missed");
  AST_MEM_UNMAPPED: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // see RL9
    !(|hit[NMEM-1:0]) |=> !mem_hit_o && mem_rdata_o == `PU_RESET_VAL) else $error("Unmapped memory read");
  AST_EXT_UNMAPPED: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // see RL9
    !(hit[NMEM] || hit[NMEM+1]) |=> !ext_hit_o && ext_rdata_o == `PU_RESET_VAL) else $error("Unmapped ext read");
endmodule // port_pullup_option_control
`default_nettype wire

// ==== dv/port_pullup_option_control_tb_top.sv ====
/*
  Bench for the pull-up option block: register access on both paths and pin enables.
  Assumes the design package and header are compiled before it.
*/
`default_nettype none
module port_pullup_option_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pullup_pkg::*;
  logic sys_clk_i = 0;
  logic resetn_i = 0;
  mem_req_t mq = '0;
  ext_req_t eq = '0;
  logic [103:0] inm = '0;
  logic [103:0] alt = '0;
  logic [103:0] pen;
  logic [103:0] ev;
  logic [7:0] mrd;
  logic [7:0] erd;
  logic mhit;
  logic ehit;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  logic [15:0] adr [11] = '{16'hff31, 16'hff33, 16'hff34, 16'hff38, 16'hff39, 16'hff3a, 16'hff3b, 16'hff3c,
    16'hff3d, 16'hff3e, 16'hff3f};
  logic [7:0] msk [13] = '{8'h0e, 8'h0f, 8'h3f, 8'h0f, 8'h0f, 8'h0f, 8'h0f, 8'h01, 8'h0f, 8'h0f, 8'h0f,
    8'h3f, 8'h3f};
  always #2.5 sys_clk_i = ~sys_clk_i;
  port_pullup_option_control dut_u (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .mem_req_i(mq),
    .ext_req_i(eq), .pin_input_mode_i(inm), .pin_alt_out_i(alt), .mem_rdata_o(mrd), .mem_hit_o(mhit),
    .ext_rdata_o(erd), .ext_hit_o(ehit), .pullup_en_o(pen));
  task automatic cmp(input logic [103:0] seen, input logic [103:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("errors %0d checks %0d", err_total, checks);
    if (err_total == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic mw(input logic [15:0] a, input logic [7:0] d, input logic bo, input logic [2:0] p,
    input logic bv);
    @(negedge sys_clk_i);
    mq = '{1'b1, bo, p, bv, a, d};
    @(negedge sys_clk_i);
    mq.we = 1'b0;
  endtask
  task automatic mr(input logic [15:0] a, input logic h, input logic [7:0] d);
    @(negedge sys_clk_i);
    mq.addr = a;
    @(negedge sys_clk_i);
    cmp({mhit, mrd}, {h, d});
  endtask
  task automatic ew(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    eq = '{1'b1, a, d};
    @(negedge sys_clk_i);
    eq.we = 1'b0;
  endtask
  task automatic er(input logic [7:0] a, input logic h, input logic [7:0] d);
    @(negedge sys_clk_i);
    eq.addr = a;
    @(negedge sys_clk_i);
    cmp({ehit, erd}, {h, d});
  endtask
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      give_verdict();
    end
  end
  initial begin
    repeat (2) @(negedge sys_clk_i);
    resetn_i = 1;
    for (int i = 0; i < 11; i++) mr(adr[i], 1'b1, 8'h00);
    er(8'h8d, 1'b1, 8'h00);
    er(8'h90, 1'b1, 8'h00);
    for (int i = 0; i < 11; i++) begin
      mw(adr[i], 8'hff, 1'b0, 3'd0, 1'b0);
      mr(adr[i], 1'b1, msk[i]);
    end
    ew(8'h8d, 8'hff);
    er(8'h8d, 1'b1, 8'h3f);
    ew(8'h90, 8'hc5);
    er(8'h90, 1'b1, 8'h05);
    mw(16'hff34, 8'hff, 1'b1, 3'd2, 1'b0);
    mr(16'hff34, 1'b1, 8'h3b);
    mw(16'hff31, 8'h00, 1'b1, 3'd7, 1'b1);
    mr(16'hff31, 1'b1, 8'h0e);
    mw(16'h008d, 8'h00, 1'b0, 3'd0, 1'b0);
    er(8'h8d, 1'b1, 8'h3f);
    mr(16'h008d, 1'b0, 8'h00);
    er(8'h8e, 1'b0, 8'h00);
    for (int i = 0; i < 13; i++) ev[8*i+:8] = msk[i];
    ev[23:16] = 8'h3b;
    ev[103:96] = 8'h05;
    inm = '1;
    @(negedge sys_clk_i);
    cmp(pen, ev);
    alt = '1;
    @(negedge sys_clk_i);
    cmp(pen, '0);
    inm = {13{8'h5f}};
    alt = {13{8'h0c}};
    @(negedge sys_clk_i);
    cmp(pen, ev & inm & ~alt);
    resetn_i = 0;
    @(negedge sys_clk_i);
    resetn_i = 1;
    @(negedge sys_clk_i);
    cmp(pen, '0);
    mr(16'hff34, 1'b1, 8'h00);
    er(8'h90, 1'b1, 8'h00);
    for (int i = 2; i < 6; i++) mw(16'hff34, 8'h00, 1'b1, 3'(i), 1'b1);
    mr(16'hff34, 1'b1, 8'h3c);
    cmp(pen, {80'h0, 8'h10, 16'h0});
    give_verdict();
  end
endmodule // port_pullup_option_control_tb_top
`default_nettype wire
